// >>> design/vtp_selector.sv
// VC-3 1+1 trail protection: bridge, selector, protection trail termination.
// Assumes every stream, strobe and command is synchronous to mclk_in.
//
// Summary of operation
// - Normal output carries working or protection stream, chosen by conditions and commands.
// - Normal input is always bridged onto the working output.
// - Mode or timer changes without an active switch leave traffic untouched.
// - Revertive mode waits the restore period after working recovers, then reverts.
// - New fail or degrade conditions are believed only after the hold-off time.
// - Each path's server signal fail is its fail switching condition, high priority.
// - Each path's server signal degrade is its degrade condition, high priority.
// - Revertive mode accepts lockout, forced and manual to protection, and clear.
// - Uni-directional non-revertive accepts lockout, forced/manual to either path, clear.
// - Bi-directional non-revertive also accepts exercise of either path.
// - Uni-directional variant switches on local conditions only, no signalling.
// - Bi-directional variant exchanges a switching signal on the protection point.
// - Protection termination source passes data, strobe and frame start unchanged.
// - Protection termination sink forwards the stream and reports the protected trail.
// - Sink trail signal fail follows its incoming server signal fail.
`timescale 1ns/1ps
module vtp_selector
	import vtp_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Configuration
	input wire logic revert_select_in,
	input wire logic switch_signalling_used_in,
	input wire logic [3:0] wait_to_restore_period_in,
	input wire logic [6:0] hold_off_period_in,
	// Operator command
	input wire logic [3:0] operator_command_in,
	input wire logic operator_command_valid_in,
	// Working path in
	input wire logic [7:0] work_data_in,
	input wire logic work_clk_en_in,
	input wire logic work_fs_in,
	input wire logic work_server_signal_fail_in,
	input wire logic work_server_signal_degrade_in,
	// Protection path in
	input wire logic [7:0] prot_data_in,
	input wire logic prot_clk_en_in,
	input wire logic prot_fs_in,
	input wire logic prot_server_signal_fail_in,
	input wire logic prot_server_signal_degrade_in,
	input wire logic [7:0] aps_rx_in,
	// Normal point in
	input wire logic [7:0] norm_data_in,
	input wire logic norm_clk_en_in,
	input wire logic norm_fs_in,
	// Protection termination source in
	input wire logic [7:0] ptso_data_in,
	input wire logic ptso_clk_en_in,
	input wire logic ptso_fs_in,
	// Protection termination sink in
	input wire logic [7:0] ptsk_data_in,
	input wire logic ptsk_clk_en_in,
	input wire logic ptsk_fs_in,
	input wire logic ptsk_server_signal_fail_in,
	input wire logic fail_report_enable_in,
	// Bridged outputs
	output logic [7:0] work_data_out,
	output logic work_clk_en_out,
	output logic work_fs_out,
	output logic [7:0] prot_data_out,
	output logic prot_clk_en_out,
	output logic prot_fs_out,
	output logic [7:0] aps_tx_out,
	// Selected output
	output logic [7:0] norm_data_out,
	output logic norm_clk_en_out,
	output logic norm_fs_out,
	output logic norm_server_signal_fail_out,
	// Status
	output logic prot_selected_out,
	output logic [3:0] active_request_out,
	output logic command_rejected_out,
	// Protection termination source out
	output logic [7:0] ptso_data_out,
	output logic ptso_clk_en_out,
	output logic ptso_fs_out,
	// Protection termination sink out
	output logic [7:0] ptsk_data_out,
	output logic ptsk_clk_en_out,
	output logic ptsk_fs_out,
	output logic trail_signal_fail_out,
	output logic fail_cause_report_out
);

	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic tick;
		vtp_cmd_e cmd;
		logic sel;
		logic wtr_run;
		logic [WTR_CNT_W-1:0] wtr_cnt;
		logic [3:0] req;
		logic rej;
		logic [7:0] aps;
		logic [9:0] work_o;
		logic [9:0] prot_o;
		logic [10:0] norm_o;
		logic [9:0] ptso_o;
		logic [11:0] ptsk_o;
	} vtp_sel_s;

	vtp_sel_s s_q;
	vtp_sel_s s_d;
	logic sf_w;
	logic sd_w;
	logic sf_p;
	logic sd_p;

	// ==========================================================
	// Condition hold-off per path
	vtp_hold_off u_ho_work (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.ms_tick_in(s_q.tick),
		.hold_off_period_in(hold_off_period_in),
		.fail_raw_in(work_server_signal_fail_in),
		.degrade_raw_in(work_server_signal_degrade_in),
		.fail_out(sf_w),
		.degrade_out(sd_w)
	);

	vtp_hold_off u_ho_prot (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.ms_tick_in(s_q.tick),
		.hold_off_period_in(hold_off_period_in),
		.fail_raw_in(prot_server_signal_fail_in),
		.degrade_raw_in(prot_server_signal_degrade_in),
		.fail_out(sf_p),
		.degrade_out(sd_p)
	);

	// ==========================================================
	// Command acceptance
	function automatic logic cmd_legal(input logic [3:0] c, input logic rev, input logic bidir);
		logic ok;
		unique case (c)
			CMD_CLEAR, CMD_LOCKOUT, CMD_FORCED_P, CMD_MANUAL_P: ok = 1'b1;
			CMD_FORCED_W, CMD_MANUAL_W: ok = !rev;
			CMD_EXERCISE_CMD_W, CMD_EXERCISE_CMD_P: ok = !rev && bidir;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : cmd_legal

	// ==========================================================
	// Selector
	always_comb begin
		logic want;
		logic [3:0] req;
		logic hold_wtr;
		s_d = s_q;
		want = s_q.sel;
		req = REQ_NONE;
		hold_wtr = 1'b0;
		s_d.tick = 1'b0;
		s_d.rej = 1'b0;
		if (s_q.presc == PRESC_W'(CYCLES_PER_MS - 1)) begin
			s_d.presc = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.presc = s_q.presc + PRESC_W'(1);
		end

		if (operator_command_valid_in) begin
			if (!cmd_legal(operator_command_in, revert_select_in, switch_signalling_used_in)) begin
				s_d.rej = 1'b1;
			end else if (operator_command_in == CMD_CLEAR) begin
				s_d.cmd = CMD_NONE;
				s_d.wtr_run = 1'b0;
			end else begin
				s_d.cmd = vtp_cmd_e'(operator_command_in);
			end
		end

		// Requests in falling priority; the top one sets the wanted path.
		if (s_q.cmd == CMD_LOCKOUT) begin
			req = REQ_LOCKOUT;
			want = 1'b0;
		end else if (sf_p) begin
			req = REQ_FAIL_P;
			want = 1'b0;
		end else if (s_q.cmd == CMD_FORCED_P || s_q.cmd == CMD_FORCED_W) begin
			req = REQ_FORCED;
			want = (s_q.cmd == CMD_FORCED_P);
		end else if (sf_w) begin
			req = REQ_FAIL_W;
			want = 1'b1;
		end else if (sd_w != sd_p) begin
			req = REQ_DEGRADE;
			want = sd_w;
		end else if (sd_w) begin
			// Both paths degraded: stay put rather than bounce traffic.
			req = REQ_DEGRADE;
		end else if (s_q.cmd == CMD_MANUAL_P || s_q.cmd == CMD_MANUAL_W) begin
			req = REQ_MANUAL;
			want = (s_q.cmd == CMD_MANUAL_P);
		end else if (s_q.sel && revert_select_in) begin
			req = REQ_WTR;
			hold_wtr = 1'b1;
			if (s_q.wtr_run && s_q.wtr_cnt >= vtp_wtr_ms(wait_to_restore_period_in)) begin
				want = 1'b0;
				hold_wtr = 1'b0;
				req = REQ_NONE;
			end
		end else if (s_q.cmd == CMD_EXERCISE_CMD_P || s_q.cmd == CMD_EXERCISE_CMD_W) begin
			req = REQ_EXERCISE;
		end else begin
			// Without a request the selection is kept, so changing mode or timers is hitless.
			req = s_q.sel ? REQ_NO_REVERT : REQ_NONE;
		end

		// Any higher local request restarts the restore period from zero.
		if (hold_wtr) begin
			s_d.wtr_run = 1'b1;
			if (s_q.tick && s_q.wtr_cnt != '1) begin
				s_d.wtr_cnt = s_q.wtr_cnt + WTR_CNT_W'(1);
			end
		end else begin
			s_d.wtr_run = 1'b0;
			s_d.wtr_cnt = '0;
		end

		// Far end wins when its request outranks ours.
		if (switch_signalling_used_in) begin
			if (aps_rx_in[APS_REQ_MSB:APS_REQ_LSB] > req) begin
				want = aps_rx_in[APS_SEL_BIT];
			end
			s_d.aps = {req, 3'h0, want};
		end else begin
			s_d.aps = 8'h00;
		end

		s_d.req = req;
		s_d.sel = want;
		s_d.norm_o = want ?
			{prot_data_in, prot_clk_en_in, prot_fs_in, prot_server_signal_fail_in} :
			{work_data_in, work_clk_en_in, work_fs_in, work_server_signal_fail_in};
		s_d.work_o = {norm_data_in, norm_clk_en_in, norm_fs_in};
		s_d.prot_o = {norm_data_in, norm_clk_en_in, norm_fs_in};
		s_d.ptso_o = {ptso_data_in, ptso_clk_en_in, ptso_fs_in};
		s_d.ptsk_o = {ptsk_data_in, ptsk_clk_en_in, ptsk_fs_in,
			ptsk_server_signal_fail_in,
			ptsk_server_signal_fail_in && fail_report_enable_in};
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
			s_q.cmd <= vtp_cmd_e'(RST_COMMAND);
			s_q.sel <= RST_SELECT_PROT;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign {work_data_out, work_clk_en_out, work_fs_out} = s_q.work_o;
	assign {prot_data_out, prot_clk_en_out, prot_fs_out} = s_q.prot_o;
	assign {norm_data_out, norm_clk_en_out, norm_fs_out, norm_server_signal_fail_out} = s_q.norm_o;
	assign {ptso_data_out, ptso_clk_en_out, ptso_fs_out} = s_q.ptso_o;
	assign {ptsk_data_out, ptsk_clk_en_out, ptsk_fs_out, trail_signal_fail_out,
		fail_cause_report_out} = s_q.ptsk_o;
	assign aps_tx_out = s_q.aps;
	assign prot_selected_out = s_q.sel;
	assign active_request_out = s_q.req;
	assign command_rejected_out = s_q.rej;

endmodule : vtp_selector

// >>> design/vtp_pkg.sv
// Constants, encodings and helpers for the VC-3 1+1 trail protection selector.
// Assumes one 50 MHz system clock; all stream strobes are on that clock.
package vtp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
	localparam int HOLD_OFF_STEP_MS = 100;
	localparam logic [6:0] HOLD_OFF_MAX_STEPS = 7'h64;
	localparam logic [3:0] WTR_MIN_MINUTES = 4'h5;
	localparam logic [3:0] WTR_MAX_MINUTES = 4'hc;
	localparam int MS_PER_MINUTE = 60_000;
	localparam int SWITCH_TIME_MS = 50;
	localparam int HO_CNT_W = 14;
	localparam int WTR_CNT_W = 20;
	localparam int PRESC_W = 16;

	// ==========================================================
	// Reset values
	localparam logic [3:0] RST_COMMAND = 4'h0;
	localparam logic RST_SELECT_PROT = 1'b0;

	// ==========================================================
	// Signalling word layout
	localparam int APS_REQ_MSB = 7;
	localparam int APS_REQ_LSB = 4;
	localparam int APS_SEL_BIT = 0;

	// ==========================================================
	// Operator commands
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_CLEAR = 4'h1,
		CMD_LOCKOUT = 4'h2,
		CMD_FORCED_W = 4'h3,
		CMD_FORCED_P = 4'h4,
		CMD_MANUAL_W = 4'h5,
		CMD_MANUAL_P = 4'h6,
		CMD_EXERCISE_CMD_W = 4'h7,
		CMD_EXERCISE_CMD_P = 4'h8
	} vtp_cmd_e;

	// Request levels, higher value wins.
	typedef enum logic [3:0] {
		REQ_NONE = 4'h0,
		REQ_NO_REVERT = 4'h1,
		REQ_EXERCISE = 4'h2,
		REQ_WTR = 4'h3,
		REQ_MANUAL = 4'h4,
		REQ_DEGRADE = 4'h5,
		REQ_FAIL_W = 4'h6,
		REQ_FORCED = 4'h7,
		REQ_FAIL_P = 4'h8,
		REQ_LOCKOUT = 4'h9
	} vtp_req_e;

	// ==========================================================
	// Helpers
	function automatic logic [HO_CNT_W-1:0] vtp_hold_off_ms(input logic [6:0] steps);
		logic [6:0] s;
		s = (steps > HOLD_OFF_MAX_STEPS) ? HOLD_OFF_MAX_STEPS : steps;
		return HO_CNT_W'(s) * HO_CNT_W'(HOLD_OFF_STEP_MS);
	endfunction : vtp_hold_off_ms

	function automatic logic [WTR_CNT_W-1:0] vtp_wtr_ms(input logic [3:0] minutes);
		logic [3:0] m;
		m = (minutes < WTR_MIN_MINUTES) ? WTR_MIN_MINUTES :
			(minutes > WTR_MAX_MINUTES) ? WTR_MAX_MINUTES : minutes;
		return WTR_CNT_W'(m) * WTR_CNT_W'(MS_PER_MINUTE);
	endfunction : vtp_wtr_ms

endpackage : vtp_pkg

// >>> design/vtp_hold_off.sv
// Hold-off filter for the fail and degrade conditions of one path.
// Assumes a one-cycle millisecond tick from the parent on the same clock.
`timescale 1ns/1ps
module vtp_hold_off
	import vtp_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Timing
	input wire logic ms_tick_in,
	input wire logic [6:0] hold_off_period_in,
	// Raw conditions
	input wire logic fail_raw_in,
	input wire logic degrade_raw_in,
	// Accepted conditions
	output logic fail_out,
	output logic degrade_out
);

	typedef struct packed {
		logic [1:0] act;
		logic [1:0][HO_CNT_W-1:0] cnt;
	} vtp_ho_s;

	vtp_ho_s s_q;
	vtp_ho_s s_d;

	// ==========================================================
	// Filter
	always_comb begin
		logic [1:0] raw;
		logic [HO_CNT_W-1:0] lim;
		raw = {degrade_raw_in, fail_raw_in};
		lim = vtp_hold_off_ms(hold_off_period_in);
		s_d = s_q;
		for (int i = 0; i < 2; i++) begin
			// A new condition is only believed once it has lasted the hold-off time;
			// a clearing condition drops at once so recovery is never delayed here.
			if (!raw[i]) begin
				s_d.act[i] = 1'b0;
				s_d.cnt[i] = '0;
			end else if (!s_q.act[i]) begin
				if (s_q.cnt[i] >= lim) begin
					s_d.act[i] = 1'b1;
				end else if (ms_tick_in) begin
					s_d.cnt[i] = s_q.cnt[i] + HO_CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign fail_out = s_q.act[0];
	assign degrade_out = s_q.act[1];

endmodule : vtp_hold_off

// >>> bench/vtp_selector_asserts.sv
// Property checker for the protection selector, bound to every instance.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module vtp_selector_asserts
	import vtp_pkg::*;
(
	// Clock and control
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic revert_select_in,
	input wire logic switch_signalling_used_in,
	input wire logic [3:0] operator_command_in,
	input wire logic operator_command_valid_in,
	// Streams and indications in
	input wire logic [7:0] work_data_in,
	input wire logic [7:0] prot_data_in,
	input wire logic [7:0] norm_data_in,
	input wire logic [7:0] ptso_data_in,
	input wire logic ptso_clk_en_in,
	input wire logic ptso_fs_in,
	input wire logic ptsk_server_signal_fail_in,
	input wire logic fail_report_enable_in,
	// Outputs watched
	input wire logic [7:0] work_data_out,
	input wire logic [7:0] norm_data_out,
	input wire logic [7:0] aps_tx_out,
	input wire logic [7:0] ptso_data_out,
	input wire logic ptso_clk_en_out,
	input wire logic ptso_fs_out,
	input wire logic prot_selected_out,
	input wire logic [3:0] active_request_out,
	input wire logic command_rejected_out,
	input wire logic trail_signal_fail_out,
	input wire logic fail_cause_report_out
);
	// ==========================================================
	// Helpers
	// The run flag keeps $past from reaching back into a reset cycle.
	logic run_q;
	logic take;
	assign take = operator_command_valid_in && ce_in;
	always_ff @(posedge mclk_in) run_q <= rst_n_in && ce_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================================
	// Properties
	bridge_work_a: assert property (run_q |-> work_data_out == $past(norm_data_in))
		else $error("working output differs from normal input");
	src_pass_a: assert property (run_q |->
		{ptso_data_out, ptso_clk_en_out, ptso_fs_out} ==
		$past({ptso_data_in, ptso_clk_en_in, ptso_fs_in})) else $error("source copy differs");
	sink_fail_a: assert property (run_q |->
		trail_signal_fail_out == $past(ptsk_server_signal_fail_in))
		else $error("trail fail does not follow server fail");
	cause_gate_a: assert property (run_q |-> fail_cause_report_out ==
		$past(ptsk_server_signal_fail_in && fail_report_enable_in)) else $error("fail cause wrong");
	sel_path_a: assert property (run_q && $stable(prot_selected_out) |-> norm_data_out ==
		(prot_selected_out ? $past(prot_data_in) : $past(work_data_in))) else $error("wrong path");
	rev_refuse_a: assert property (take && revert_select_in && operator_command_in inside
		{CMD_FORCED_W, CMD_MANUAL_W, CMD_EXERCISE_CMD_W, CMD_EXERCISE_CMD_P} |=> command_rejected_out)
		else $error("revertive mode took an illegal command");
	uni_refuse_a: assert property (take && !revert_select_in &&
		!switch_signalling_used_in && operator_command_in inside {CMD_EXERCISE_CMD_W, CMD_EXERCISE_CMD_P}
		|=> command_rejected_out) else $error("one-ended mode took exercise");
	bi_exercise_a: assert property (take && !revert_select_in &&
		switch_signalling_used_in && operator_command_in inside {CMD_EXERCISE_CMD_W, CMD_EXERCISE_CMD_P}
		|=> !command_rejected_out) else $error("two-ended mode refused exercise");
	uni_quiet_a: assert property (run_q && !$past(switch_signalling_used_in) |->
		aps_tx_out == 8'h00) else $error("signalling sent in one-ended mode");
	lockout_hold_a: assert property (take && operator_command_in == CMD_LOCKOUT ##1
		ce_in && !switch_signalling_used_in |=> !prot_selected_out && active_request_out == REQ_LOCKOUT)
		else $error("lockout did not hold working");
endmodule : vtp_selector_asserts

bind vtp_selector vtp_selector_asserts chk_i (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
	.revert_select_in(revert_select_in), .switch_signalling_used_in(switch_signalling_used_in),
	.operator_command_in(operator_command_in),
	.operator_command_valid_in(operator_command_valid_in),
	.work_data_in(work_data_in), .prot_data_in(prot_data_in), .norm_data_in(norm_data_in),
	.ptso_data_in(ptso_data_in), .ptso_clk_en_in(ptso_clk_en_in), .ptso_fs_in(ptso_fs_in),
	.ptsk_server_signal_fail_in(ptsk_server_signal_fail_in),
	.fail_report_enable_in(fail_report_enable_in),
	.work_data_out(work_data_out), .norm_data_out(norm_data_out), .aps_tx_out(aps_tx_out),
	.ptso_data_out(ptso_data_out), .ptso_clk_en_out(ptso_clk_en_out), .ptso_fs_out(ptso_fs_out),
	.prot_selected_out(prot_selected_out), .active_request_out(active_request_out),
	.command_rejected_out(command_rejected_out), .trail_signal_fail_out(trail_signal_fail_out),
	.fail_cause_report_out(fail_cause_report_out)
);

// >>> bench/vtp_path_model.sv
// Model of one path's upstream termination and adaptation.
// Assumes the bench clock; fail and degrade requests come from the bench.
`timescale 1ns/1ps
module vtp_path_model #(
	parameter logic [7:0] START = 8'h00
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Requested conditions
	input wire logic fail_in,
	input wire logic degrade_in,
	// Stream and indications
	output logic [7:0] data_out,
	output logic clk_en_out,
	output logic fs_out,
	output logic ssf_out,
	output logic ssd_out
);
	// ==========================================================
	// Stream
	// Data moves every cycle, strobed or not, so a stale byte never passes for a fresh one.
	logic [7:0] cnt_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			cnt_q <= START;
		else
			cnt_q <= cnt_q + 8'h01;
		ssf_out <= fail_in;
		ssd_out <= degrade_in;
	end
	assign data_out = cnt_q ^ 8'h5a;
	assign clk_en_out = cnt_q[0];
	assign fs_out = (cnt_q == START);
endmodule : vtp_path_model

// >>> bench/vtp_selector_bench.sv
// Self-checking bench for the protection selector.
// Assumes the package, design, path model and checker are compiled first.
`timescale 1ns/1ps
module vtp_selector_bench;
	import vtp_pkg::*;
	// ==========================================================
	// Signals
	logic mclk = 0, rst_n = 0, rev = 1, sig = 0, cv = 0, wf = 0, wdg = 0, pf = 0, ksf = 0, ren = 0;
	logic [3:0] oc = 4'h0, wtr = 4'h5, areq;
	logic [6:0] ho = 7'h00;
	logic [7:0] nd = 8'h00, sd = 8'h00, kd = 8'h00, aps = 8'h00, wdi, pdi, wdo, ndo, pko, apo;
	logic [5:0] st = 6'h00;
	logic wce, wfs, wsf, wsd, pce, pfs, psf, psd, psel, rej;
	logic ce = 1, pdg = 0, rej_seen;
	logic [7:0] pdo, hold_v;
	logic [5:0] fo;
	logic [2:0] nso;
	int mismatches = 0, n_checks = 0;

	initial forever #10 mclk = ~mclk;

	vtp_path_model #(.START(8'h00)) wm (.clk_in(mclk), .rst_n_in(rst_n), .fail_in(wf),
		.degrade_in(wdg), .data_out(wdi), .clk_en_out(wce), .fs_out(wfs), .ssf_out(wsf), .ssd_out(wsd));
	vtp_path_model #(.START(8'h80)) pm (.clk_in(mclk), .rst_n_in(rst_n), .fail_in(pf),
		.degrade_in(pdg), .data_out(pdi), .clk_en_out(pce), .fs_out(pfs), .ssf_out(psf), .ssd_out(psd));
	vtp_selector #(.CYCLES_PER_MS(10)) dut (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce),
		.revert_select_in(rev), .switch_signalling_used_in(sig), .wait_to_restore_period_in(wtr),
		.hold_off_period_in(ho), .operator_command_in(oc), .operator_command_valid_in(cv),
		.work_data_in(wdi), .work_clk_en_in(wce), .work_fs_in(wfs), .work_server_signal_fail_in(wsf),
		.work_server_signal_degrade_in(wsd), .prot_data_in(pdi), .prot_clk_en_in(pce),
		.prot_fs_in(pfs), .prot_server_signal_fail_in(psf), .prot_server_signal_degrade_in(psd),
		.aps_rx_in(aps), .norm_data_in(nd), .norm_clk_en_in(st[0]), .norm_fs_in(st[1]),
		.ptso_data_in(sd), .ptso_clk_en_in(st[2]), .ptso_fs_in(st[3]), .ptsk_data_in(kd),
		.ptsk_clk_en_in(st[4]), .ptsk_fs_in(st[5]), .ptsk_server_signal_fail_in(ksf),
		.fail_report_enable_in(ren), .work_data_out(wdo), .work_clk_en_out(fo[0]),
		.work_fs_out(fo[1]), .prot_data_out(pdo), .prot_clk_en_out(fo[2]), .prot_fs_out(fo[3]),
		.aps_tx_out(apo), .norm_data_out(ndo), .norm_clk_en_out(nso[0]), .norm_fs_out(nso[1]),
		.norm_server_signal_fail_out(nso[2]), .prot_selected_out(psel),
		.active_request_out(areq), .command_rejected_out(rej), .ptso_data_out(), .ptso_clk_en_out(),
		.ptso_fs_out(), .ptsk_data_out(pko), .ptsk_clk_en_out(fo[4]), .ptsk_fs_out(fo[5]),
		.trail_signal_fail_out(), .fail_cause_report_out());

	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic exp_rej(input int m, input int c);
		return (c > 8) || (m == 0 && c inside {3, 5, 7, 8}) || (m == 1 && c > 6);
	endfunction : exp_rej

	// One cycle per pass; the selected path is compared only while selection stands still.
	task automatic cyc(input int n);
		logic [7:0] pn, pk, pw, pp;
		logic [5:0] pf6;
		logic [2:0] nw, np;
		logic r, s;
		repeat (n) begin
			{pn, pk, pw, pp, r, s} = {nd, kd, wdi, pdi, rst_n && ce, psel};
			pf6 = {st[5:4], st[1:0], st[1:0]};
			{nw, np} = {wsf, wfs, wce, psf, pfs, pce};
			@(posedge mclk);
			#1;
			if (r) begin
				chk(wdo, pn);
				chk(pdo, pn);
				chk({2'h0, fo}, {2'h0, pf6});
				chk(pko, pk);
				if (psel === s) chk(ndo, s ? pp : pw);
				if (psel === s) chk({5'h0, nso}, {5'h0, s ? np : nw});
			end
			{nd, sd, kd} = 24'($urandom);
			{st, ksf, ren} = 8'($urandom);
		end
	endtask : cyc

	task automatic cmd(input logic [3:0] c);
		oc = c;
		cv = 1;
		cyc(1);
		rej_seen = rej;
		cv = 0;
		cyc(1);
	endtask : cmd

	task automatic wsel(input logic e, input int lim);
		repeat (lim) if (psel !== e) cyc(1);
	endtask : wsel

	task automatic restart;
		{wf, wdg, pf, pdg, aps} = '0;
		rst_n = 0;
		cyc(2);
		rst_n = 1;
	endtask : restart

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Tests
	// The whole run needs under two thousand cycles; ten times that means a hang.
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h8685));
		cyc(16);
		rst_n = 1;
		for (int i = 0; i < 8; i++) begin
			{rev, wtr, ho} = 12'($urandom);
			cyc(5);
		end
		chk(psel, 1'b0);
		$display("test settings change done");
		for (int m = 0; m < 3; m++) begin
			{rev, sig} = {m == 0, m == 2};
			for (int c = 1; c < 10; c++) begin
				cmd(4'(c));
				chk(rej_seen, exp_rej(m, c));
				if (m == 2 && c > 6 && c < 9) chk(areq, REQ_EXERCISE);
				cmd(CMD_CLEAR);
			end
		end
		$display("test command sets done");
		rev = 1;
		sig = 0;
		ho = 7'h00;
		restart;
		pf = 1;
		cyc(3);
		cmd(CMD_FORCED_P);
		cyc(1);
		chk(psel, 1'b0);
		chk(areq, REQ_FAIL_P);
		pf = 0;
		wsel(1'b1, 8);
		chk(areq, REQ_FORCED);
		cyc(20);
		cmd(CMD_LOCKOUT);
		cyc(1);
		chk(psel, 1'b0);
		$display("test priority done");
		for (int r = 1; r >= 0; r--) begin
			rev = r[0];
			restart;
			wf = 1;
			wsel(1'b1, 8);
			chk(areq, REQ_FAIL_W);
			cyc(10);
			wf = 0;
			cyc(5);
			chk(psel, 1'b1);
			chk(areq, r ? REQ_WTR : REQ_NO_REVERT);
		end
		$display("test working fail done");
		ho = 7'h01;
		restart;
		wdg = 1;
		cyc(980);
		chk(psel, 1'b0);
		wsel(1'b1, 60);
		chk(areq, REQ_DEGRADE);
		ho = 7'h00;
		pdg = 1;
		cyc(5);
		chk(psel, 1'b1);
		wdg = 0;
		wsel(1'b0, 8);
		chk(areq, REQ_DEGRADE);
		$display("test hold-off done");
		ho = 7'h00;
		sig = 1;
		restart;
		aps = 8'h71;
		wsel(1'b1, 8);
		chk(psel, 1'b1);
		cyc(1);
		chk(apo, {REQ_NO_REVERT, 4'h1});
		$display("test far-end request done");
		hold_v = wdo;
		ce = 0;
		cyc(4);
		chk(wdo, hold_v);
		chk(psel, 1'b1);
		ce = 1;
		cyc(2);
		$display("test clock enable done");
		complete_run();
	end
endmodule : vtp_selector_bench
